// ==== hw/epi_cfg.svh ====
/*
  Constants of the external pin interrupt unit: register indices,
  field positions, reset values and vector addresses.
  Assumes inclusion by bare name from the design file.
*/
`ifndef EPI_CFG_SVH
`define EPI_CFG_SVH

// Register indices; the byte address is four times the index.
`define EPI_IDX_PCMASK 6'h15
`define EPI_IDX_MCUCTL 6'h35
`define EPI_IDX_FLAGS 6'h3A
`define EPI_IDX_IMASK 6'h3B
`define EPI_IDX_GIE 6'h3F

// Field positions.
`define EPI_SENSE_HI 1
`define EPI_SENSE_LO 0
`define EPI_BIT_DED 6
`define EPI_BIT_PC 5
`define EPI_PC_HI 5
`define EPI_MCU_HI 6
`define EPI_MCU_LO 3
`define EPI_NPINS 6

// Reset values and read masks.
`define EPI_RST_BYTE 8'h00
`define EPI_MASK_PCMASK 8'h3F
`define EPI_MASK_MCUCTL 8'h7B
`define EPI_MASK_EN 8'h60
`define EPI_MASK_GIE 8'h01

// Vector addresses.
`define EPI_VEC_NONE 16'h0000
`define EPI_VEC_DED 16'h0001
`define EPI_VEC_PC 16'h0002

`endif

// ==== hw/epi_pkg.sv ====
/*
  Types of the external pin interrupt unit.
  Assumes nothing of its surroundings.
*/
package epi_pkg;

  // Trigger choices of the dedicated pin.
  typedef enum logic [1:0] {
    EPI_LOW = 2'b00,
    EPI_ANY = 2'b01,
    EPI_FALL = 2'b10,
    EPI_RISE = 2'b11
  } epi_sense_t;

endpackage

// ==== hw/epi_top.sv ====
/*
  External pin interrupt unit: one dedicated pin with selectable sense
  and six maskable pin-change inputs, with flags, enables and vectors,
  reached over APB.
  Assumes pins come from outside the clock domain and that the core
  pulses i_vec_ack when it enters the routine shown on o_vector.
*/
// Our own choice: the APB register port.
// Operation
// - Sense field bits 1:0 pick low, any change, falling or rising edge.
// - Pin is sampled before edge detection; pulses over one clock register. Here a level must hold for two successive samples to count.
// - Dedicated interrupt needs mask bit 6 and the global enable.
// - Pin activity requests even when the pin is an output.
// - Pin-change interrupt needs mask bit 5 and the global enable.
// - Six mask bits 5:0 at 0x15 enable each pin's change detection.
// - Flag bit 6 at 0x3A sets on a dedicated pin edge or change.
// - Flag bit 5 sets on a change of any enabled pin-change input.
// - Pending, enabled flag directs the core to its vector.
// - Flags clear on routine entry or by writing one.
// - Dedicated flag stays cleared while low-level sensing is chosen.
// - Reserved bits read as zero.
// - Vectors are 0x0001 dedicated, 0x0002 pin change.
// - Pin-change and low-level detection work without clock; edges need it. Here all detection is clocked.
`timescale 1ns/1ps

module epi_top (
  // Clock and reset.
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // APB slave.
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Pins.
  input wire logic i_dedicated_irq_pin,
  input wire logic [5:0] i_pin_change_inputs,
  // Core side.
  input wire logic i_vec_ack,
  output logic o_irq,
  output logic [15:0] o_vector
);
`include "epi_cfg.svh"

  logic [2:0] ded_sync_reg, ded_sync_next;
  logic ded_filt_reg, ded_filt_next;
  logic [5:0] pc_s1_reg, pc_s2_reg, pc_s3_reg, pc_filt_reg;
  logic [5:0] pc_s1_next, pc_s2_next, pc_s3_next, pc_filt_next;
  logic [7:0] pcmask_reg, pcmask_next;
  logic [7:0] mcuctl_reg, mcuctl_next;
  logic [7:0] imask_reg, imask_next;
  logic gie_reg, gie_next;
  logic flag_ded_reg, flag_ded_next;
  logic flag_pc_reg, flag_pc_next;
  logic irq_reg, irq_next;
  logic [15:0] vec_reg, vec_next;
  logic [31:0] prdata_reg, prdata_next;
  logic pready_reg, pready_next;
  logic pslverr_reg, pslverr_next;
  epi_pkg::epi_sense_t sense;
  logic ded_evt, pc_evt, wr_en, hit;
  logic clr_ded, clr_pc, req_ded, req_pc;
  logic [5:0] idx;
  logic [7:0] rd_byte;

  // Synchronisers: the first stage feeds only the second; a new level
  // counts once stages two and three agree.
  always_comb begin
    ded_sync_next = {ded_sync_reg[1:0], i_dedicated_irq_pin};
    pc_s1_next = i_pin_change_inputs;
    pc_s2_next = pc_s1_reg;
    pc_s3_next = pc_s2_reg;
    ded_filt_next = ded_filt_reg;
    if (ded_sync_reg[1] == ded_sync_reg[2]) begin
      ded_filt_next = ded_sync_reg[2];
    end
    pc_filt_next = pc_filt_reg;
    for (int i = 0; i < `EPI_NPINS; i++) begin
      if (pc_s2_reg[i] == pc_s3_reg[i]) begin
        pc_filt_next[i] = pc_s3_reg[i];
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      ded_sync_reg <= 3'h0;
      ded_filt_reg <= 1'b0;
      pc_s1_reg <= 6'h00;
      pc_s2_reg <= 6'h00;
      pc_s3_reg <= 6'h00;
      pc_filt_reg <= 6'h00;
    end else begin
      ded_sync_reg <= ded_sync_next;
      ded_filt_reg <= ded_filt_next;
      pc_s1_reg <= pc_s1_next;
      pc_s2_reg <= pc_s2_next;
      pc_s3_reg <= pc_s3_next;
      pc_filt_reg <= pc_filt_next;
    end
  end

  // Event detection on the filtered samples. Detection here is clocked;
  // a clockless wake path belongs to the power controller.
  // Comparing the filtered value with its next value sees each change once.
  always_comb begin
    sense = epi_pkg::epi_sense_t'(mcuctl_reg[`EPI_SENSE_HI:`EPI_SENSE_LO]);
    case (sense)
      epi_pkg::EPI_ANY: ded_evt = ded_filt_next != ded_filt_reg;
      epi_pkg::EPI_FALL: ded_evt = ded_filt_reg & ~ded_filt_next;
      epi_pkg::EPI_RISE: ded_evt = ~ded_filt_reg & ded_filt_next;
      default: ded_evt = 1'b0;
    endcase
    pc_evt = |((pc_filt_next ^ pc_filt_reg) & pcmask_reg[`EPI_PC_HI:0]);
  end

  // APB decode: one wait state, so every answer comes from a flop.
  // The cost is one extra cycle per access, which software never notices.
  always_comb begin
    idx = i_paddr[7:2];
    hit = (i_paddr[1:0] == 2'h0) && ((idx == `EPI_IDX_PCMASK) ||
          (idx == `EPI_IDX_MCUCTL) || (idx == `EPI_IDX_FLAGS) ||
          (idx == `EPI_IDX_IMASK) || (idx == `EPI_IDX_GIE));
    wr_en = i_psel & i_penable & pready_reg & i_pwrite & hit;
    case (idx)
      `EPI_IDX_PCMASK: rd_byte = pcmask_reg & `EPI_MASK_PCMASK;
      `EPI_IDX_MCUCTL: rd_byte = mcuctl_reg & `EPI_MASK_MCUCTL;
      `EPI_IDX_FLAGS: rd_byte = {1'b0, flag_ded_reg, flag_pc_reg, 5'h00};
      `EPI_IDX_IMASK: rd_byte = imask_reg & `EPI_MASK_EN;
      `EPI_IDX_GIE: rd_byte = {7'h00, gie_reg};
      default: rd_byte = `EPI_RST_BYTE;
    endcase
    pready_next = i_psel & i_penable & ~pready_reg;
    pslverr_next = pready_next & ~hit;
    prdata_next = 32'h0000_0000;
    if (pready_next && hit && !i_pwrite) begin
      prdata_next = {24'h00_0000, rd_byte};
    end
  end

  // Configuration writes; reserved bits are never stored.
  always_comb begin
    pcmask_next = pcmask_reg;
    mcuctl_next = mcuctl_reg;
    imask_next = imask_reg;
    gie_next = gie_reg;
    if (wr_en) begin
      case (idx)
        `EPI_IDX_PCMASK: pcmask_next = i_pwdata[7:0] & `EPI_MASK_PCMASK;
        `EPI_IDX_MCUCTL: mcuctl_next = i_pwdata[7:0] & `EPI_MASK_MCUCTL;
        `EPI_IDX_IMASK: imask_next = i_pwdata[7:0] & `EPI_MASK_EN;
        `EPI_IDX_GIE: gie_next = i_pwdata[0];
        default: gie_next = gie_reg;
      endcase
    end
  end

  // Flags: set wins over a clear in the same cycle.
  // An edge that lands with a clear would otherwise vanish unseen.
  always_comb begin
    clr_ded = (wr_en && idx == `EPI_IDX_FLAGS && i_pwdata[`EPI_BIT_DED]) ||
              (i_vec_ack && vec_reg == `EPI_VEC_DED);
    clr_pc = (wr_en && idx == `EPI_IDX_FLAGS && i_pwdata[`EPI_BIT_PC]) ||
             (i_vec_ack && vec_reg == `EPI_VEC_PC);
    flag_ded_next = ded_evt | (flag_ded_reg & ~clr_ded);
    if (sense == epi_pkg::EPI_LOW) begin
      flag_ded_next = 1'b0;
    end
    flag_pc_next = pc_evt | (flag_pc_reg & ~clr_pc);
  end

  // Request and vector; the dedicated pin has priority.
  always_comb begin
    req_ded = gie_reg & imask_reg[`EPI_BIT_DED] &
              ((sense == epi_pkg::EPI_LOW) ? ~ded_filt_reg : flag_ded_reg);
    req_pc = gie_reg & imask_reg[`EPI_BIT_PC] & flag_pc_reg;
    irq_next = req_ded | req_pc;
    if (req_ded) begin
      vec_next = `EPI_VEC_DED;
    end else if (req_pc) begin
      vec_next = `EPI_VEC_PC;
    end else begin
      vec_next = `EPI_VEC_NONE;
    end
  end

  // State registers.
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      pcmask_reg <= `EPI_RST_BYTE;
      mcuctl_reg <= `EPI_RST_BYTE;
      imask_reg <= `EPI_RST_BYTE;
      gie_reg <= 1'b0;
      flag_ded_reg <= 1'b0;
      flag_pc_reg <= 1'b0;
      irq_reg <= 1'b0;
      vec_reg <= `EPI_VEC_NONE;
      prdata_reg <= 32'h0000_0000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      pcmask_reg <= pcmask_next;
      mcuctl_reg <= mcuctl_next;
      imask_reg <= imask_next;
      gie_reg <= gie_next;
      flag_ded_reg <= flag_ded_next;
      flag_pc_reg <= flag_pc_next;
      irq_reg <= irq_next;
      vec_reg <= vec_next;
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
    end
  end

  assign o_prdata = prdata_reg;
  assign o_pready = pready_reg;
  assign o_pslverr = pslverr_reg;
  assign o_irq = irq_reg;
  assign o_vector = vec_reg;

  // Checks on the logic above.
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);

  chk_low_flag_clear: assert property (
    sense == epi_pkg::EPI_LOW |=> !flag_ded_reg)
    else $error("dedicated flag set in low mode");
  chk_rise_sets_flag: assert property (
    sense == epi_pkg::EPI_RISE && !ded_filt_reg && ded_filt_next
    |=> flag_ded_reg)
    else $error("rising edge lost");
  chk_pin_pulse: assert property (
    sense == epi_pkg::EPI_ANY && $rose(ded_sync_reg[2]) && ded_sync_reg[1]
    && ded_filt_reg == 1'b0 |=> flag_ded_reg)
    else $error("stable pulse not flagged");
  chk_pc_masked: assert property (
    pcmask_reg == 8'h00 && !flag_pc_reg && !(wr_en && idx == `EPI_IDX_PCMASK)
    |=> !flag_pc_reg)
    else $error("masked pin change set flag");
  chk_pc_sets: assert property (
    pc_evt |=> flag_pc_reg)
    else $error("pin change lost");
  chk_irq_gate: assert property (
    !gie_reg |=> !irq_reg)
    else $error("irq without global enable");
  chk_vec_ded: assert property (
    req_ded |=> o_irq && o_vector == 16'h0001)
    else $error("wrong dedicated vector");
  chk_vec_pc: assert property (
    req_pc && !req_ded |=> o_irq && o_vector == 16'h0002)
    else $error("wrong pin change vector");
  chk_w1c_clear: assert property (
    wr_en && idx == `EPI_IDX_FLAGS && i_pwdata[`EPI_BIT_PC] && !pc_evt
    |=> !flag_pc_reg)
    else $error("write one did not clear");
  chk_rsvd_zero: assert property (
    o_pready && !o_pslverr |-> o_prdata[31:8] == 24'h00_0000)
    else $error("reserved bits nonzero");
  chk_apb_wait: assert property (
    i_psel && i_penable && !o_pready |=> o_pready ##1 !o_pready)
    else $error("answer timing wrong");

  // Further checks on edge modes, routine entry and refused accesses.
  chk_fall_sets_flag: assert property (
    sense == epi_pkg::EPI_FALL && ded_filt_reg && !ded_filt_next
    |=> flag_ded_reg)
    else $error("falling edge lost");
  chk_any_sets_flag: assert property (
    sense == epi_pkg::EPI_ANY && ded_filt_reg != ded_filt_next
    |=> flag_ded_reg)
    else $error("dedicated pin change lost");
  chk_low_level_irq: assert property (
    sense == epi_pkg::EPI_LOW && gie_reg && imask_reg[`EPI_BIT_DED] && !ded_filt_reg
    |=> o_irq && o_vector == `EPI_VEC_DED)
    else $error("low level did not request");
  chk_ack_clears: assert property (
    i_vec_ack && o_vector == `EPI_VEC_PC && !pc_evt
    |=> !flag_pc_reg)
    else $error("routine entry did not clear");
  chk_pc_gate: assert property (
    !imask_reg[`EPI_BIT_PC] && !req_ded |=> !o_irq)
    else $error("pin change irq while disabled");
  chk_flag_rsvd: assert property (
    o_pready && !i_pwrite && i_paddr == {`EPI_IDX_FLAGS, 2'h0}
    |-> o_prdata[7] == 1'b0 && o_prdata[4:0] == 5'h00)
    else $error("reserved flag bits nonzero");
  chk_mcu_rsvd: assert property (
    o_pready && !i_pwrite && i_paddr == {`EPI_IDX_MCUCTL, 2'h0}
    |-> o_prdata[7] == 1'b0 && o_prdata[2] == 1'b0)
    else $error("reserved control bits nonzero");
  chk_err_no_write: assert property (
    o_pslverr |=> $stable(pcmask_reg) && $stable(mcuctl_reg) && $stable(imask_reg)
    && $stable(gie_reg))
    else $error("refused access changed a register");

  cov_ded_irq: cover property (req_ded ##1 i_vec_ack);
  cov_pc_irq: cover property (req_pc ##1 i_vec_ack);
  cov_both: cover property (flag_ded_reg && flag_pc_reg);
  cov_slverr: cover property (o_pslverr);
  cov_low_irq: cover property (sense == epi_pkg::EPI_LOW && o_irq);

endmodule

// ==== verification/epi_pin_drv.sv ====
/*
  Behavioural source of the interrupt unit's pins.
  Assumes the bench sets target levels just after rising clock edges.
*/
`timescale 1ns/1ps

module epi_pin_drv (
  // Clock.
  input wire logic i_ref_clk,
  // Target levels and pace.
  input wire logic i_ded_level,
  input wire logic [5:0] i_pc_level,
  input wire logic i_slow,
  // Pin levels.
  output logic o_ded,
  output logic [5:0] o_pc
);
  logic [6:0] dly_q [0:2];

  // Pins follow targets one or three cycles late; slowness shifts a pulse, never narrows it.
  // A level is held for as long as the bench asks, so a low request lasts long enough.
  always_ff @(posedge i_ref_clk) begin
    dly_q[0] <= {i_ded_level, i_pc_level};
    dly_q[1] <= dly_q[0];
    dly_q[2] <= dly_q[1];
  end
  assign {o_ded, o_pc} = i_slow ? dly_q[2] : dly_q[0];
endmodule

// ==== verification/tb_external_pin_interrupt_unit.sv ====
/*
  Self-checking bench of the pin interrupt unit: APB tasks and sequences.
  Assumes the one-wait-state slave and the pin filter delays of the design.
*/
`timescale 1ns/1ps
`include "epi_cfg.svh"
`define CHK(e, a) begin n_checks++; if ((a) !== (e)) begin fails++; \
  $display("MISMATCH t=%0t exp=%h act=%h", $time, e, a); end end

module tb_external_pin_interrupt_unit;
  localparam logic [7:0] A_PCM = {`EPI_IDX_PCMASK, 2'b00};
  localparam logic [7:0] A_MCU = {`EPI_IDX_MCUCTL, 2'b00};
  localparam logic [7:0] A_FLG = {`EPI_IDX_FLAGS, 2'b00};
  localparam logic [7:0] A_EN = {`EPI_IDX_IMASK, 2'b00};
  localparam logic [7:0] A_GIE = {`EPI_IDX_GIE, 2'b00};
  logic clk, rst, psel, penable, pwrite, pready, pslverr, re;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rq;
  logic ded_lvl, slow, ded_pin, vec_ack, irq;
  logic [5:0] pc_lvl, pc_pin;
  logic [15:0] vector;
  logic [7:0] ra [0:4] = '{A_PCM, A_MCU, A_FLG, A_EN, A_GIE};
  logic [7:0] rm [0:4] = '{8'h3F, 8'h7B, 8'h00, 8'h60, 8'h01};
  int fails = 0;
  int n_checks = 0;
  int cyc = 0;

  epi_top epi_top_i (.i_ref_clk(clk), .i_rst(rst), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_dedicated_irq_pin(ded_pin),
    .i_pin_change_inputs(pc_pin), .i_vec_ack(vec_ack), .o_irq(irq), .o_vector(vector));
  epi_pin_drv epi_pin_drv_i (.i_ref_clk(clk), .i_ded_level(ded_lvl), .i_pc_level(pc_lvl),
    .i_slow(slow), .o_ded(ded_pin), .o_pc(pc_pin));

  // Free-running 250 MHz clock.
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Prints the counts and the verdict, then stops.
  task automatic conclude();
    $display("checks=%0d mismatches=%0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // A hung handshake would otherwise stall the run forever.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      fails++;
      conclude();
    end
  end

  // One APB transfer; entered just after a rising edge, waits for pready.
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rq = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    `CHK({1'b0, 24'h0, e}, {re, rq})
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic ack();
    vec_ack <= 1'b1;
    @(posedge clk);
    vec_ack <= 1'b0;
    wt(4);
  endtask

  // Main sequence.
  initial begin
    {rst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 43'h0};
    {ded_lvl, pc_lvl, slow, vec_ack} = 9'h000;
    wt(8);
    rst <= 1'b0;
    wt(1);
    for (int i = 0; i < 5; i++) begin
      rd(ra[i], 8'h00);
      apb(1'b1, ra[i], 8'hFF);
      rd(ra[i], rm[i]);
      apb(1'b1, ra[i], 8'h00);
    end
    // Unmapped and misaligned addresses are refused with zero data.
    for (int i = 0; i < 2; i++) begin
      apb(1'b0, i ? 8'h55 : 8'h00, 8'h00);
      `CHK(33'h1_0000_0000, {re, rq})
    end
    // Every edge mode, each direction of the pin, cleared by writing one.
    for (int m = 1; m < 4; m++) begin
      apb(1'b1, A_MCU, 8'(m));
      ded_lvl <= 1'b1;
      wt(10);
      rd(A_FLG, (m != epi_pkg::EPI_FALL) ? 8'h40 : 8'h00);
      apb(1'b1, A_FLG, 8'h40);
      rd(A_FLG, 8'h00);
      ded_lvl <= 1'b0;
      wt(10);
      rd(A_FLG, (m != epi_pkg::EPI_RISE) ? 8'h40 : 8'h00);
      apb(1'b1, A_FLG, 8'h40);
    end
    // A two-cycle pulse from a slow source still registers.
    slow <= 1'b1;
    ded_lvl <= 1'b1;
    wt(2);
    ded_lvl <= 1'b0;
    wt(12);
    rd(A_FLG, 8'h40);
    slow <= 1'b0;
    apb(1'b1, A_EN, 8'h40);
    wt(4);
    `CHK(1'b0, irq)
    apb(1'b1, A_GIE, 8'h01);
    wt(2);
    `CHK(17'h1_0001, {irq, vector})
    ack();
    `CHK(1'b0, irq)
    rd(A_FLG, 8'h00);
    // An edge flag left pending is wiped once low level sensing is chosen.
    ded_lvl <= 1'b1;
    wt(10);
    ded_lvl <= 1'b0;
    wt(10);
    rd(A_FLG, 8'h40);
    // Low level requests while the pin is low, without any flag.
    apb(1'b1, A_MCU, 8'h00);
    wt(10);
    `CHK(17'h1_0001, {irq, vector})
    rd(A_FLG, 8'h00);
    ded_lvl <= 1'b1;
    wt(10);
    `CHK(1'b0, irq)
    // Pin change: a masked pin is ignored, an enabled one flags and vectors.
    apb(1'b1, A_MCU, 8'h03);
    apb(1'b1, A_PCM, 8'h01);
    apb(1'b1, A_EN, 8'h20);
    pc_lvl <= 6'h02;
    wt(10);
    rd(A_FLG, 8'h00);
    pc_lvl <= 6'h03;
    wt(10);
    rd(A_FLG, 8'h20);
    `CHK(17'h1_0002, {irq, vector})
    ack();
    rd(A_FLG, 8'h00);
    apb(1'b1, A_GIE, 8'h00);
    pc_lvl <= 6'h02;
    wt(10);
    rd(A_FLG, 8'h20);
    `CHK(1'b0, irq)
    conclude();
  end
endmodule
